// >>> verif/cmdc_host_model.sv
// host controller model issuing single byte register cycles
// assumes the block samples its strobes on the rising clock edge
`default_nettype none
module cmdc_host_model (
	// clock
	input wire logic clk,
	// register port
	output logic [7:0] addr,
	output logic [7:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [7:0] rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end
	// one write; released lines invert so stale values are never trusted
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge clk);
		#1;
		wr = 1'b0;
		addr = ~a;
		wdata = ~d;
	endtask
	// one read; data taken a cycle late since it holds until the next read
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		addr = a;
		rd = 1'b1;
		@(posedge clk);
		#1;
		rd = 1'b0;
		addr = ~a;
		@(posedge clk);
		#1;
		d = rdata;
	endtask
endmodule
`default_nettype wire

// >>> verif/cmdc_regs_tb.sv
// self-checking bench for the codec mode, dac and level control registers
// assumes the host model drives the register port and the bench drives streams
`default_nettype none
module cmdc_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 1'b0, srst = 1'b1, pdn_n = 1'b1, spk_pwr = 1'b0, mic_pwr = 1'b0;
	logic av = 1'b0, dv = 1'b0, hv = 1'b0;
	logic [15:0] adc = 16'h0000, din = 16'h0000, hl = 16'h0000, hr = 16'h0000;
	logic [7:0] ra, rw, rdata, rv, att_l, att_r, mute;
	logic wr, rd, oe, neg, isup, esup, second_level_ctrl;
	logic dov, mg, ms, mad, aad, rtick;
	logic [6:0] gain;
	logic [15:0] dout, hlo, hro;
	logic [2:0] fs;
	logic [1:0] dem, bst;
	int failures = 0, checked = 0;
	always #2.5 mclk = ~mclk;
	cmdc_host_model host_u (.clk(mclk), .addr(ra), .wdata(rw), .wr(wr), .rd(rd), .rdata(rdata));
	cmdc_regs dut_u (.MCLK(mclk), .SRST(srst), .POWER_DOWN_PIN_N(pdn_n), .REG_ADDR(ra), .REG_WDATA(rw),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .SPEAKER_BLOCK_POWER(spk_pwr), .MIC_BLOCK_POWER(mic_pwr),
		.ADC_DATA(adc), .ADC_VALID(av), .DAC_IN_DATA(din), .DAC_IN_VALID(dv), .DAC_OUT_DATA(dout),
		.DAC_OUT_VALID(dov), .HP_LEFT_IN(hl), .HP_RIGHT_IN(hr), .HP_IN_VALID(hv), .HP_LEFT_OUT(hlo),
		.HP_RIGHT_OUT(hro), .SPEAKER_POS_OUT_OE(oe), .SPEAKER_NEG_OUT_HALF(neg), .SAMPLE_RATE_SEL(fs),
		.DEEMPH_SEL(dem), .BASS_BOOST_SEL(bst), .LEFT_ATTEN(att_l), .RIGHT_ATTEN(att_r), .MUTE_GAIN(mute),
		.FIRST_MIC_GAIN(mg), .MIC_SOURCE_SEL(ms), .MIC_TO_ADC_SWITCH(mad), .AUX_TO_ADC_SWITCH(aad),
		.INTERNAL_MIC_SUPPLY(isup), .EXTERNAL_MIC_SUPPLY(esup), .INPUT_GAIN_STAGE(gain),
		.SECOND_LEVEL_CTRL(second_level_ctrl), .SECOND_RECOVERY_TICK(rtick));
	// ****************************************
	// shared helpers
	// ****************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic step;
		@(posedge mclk);
		#1;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		host_u.read_reg(a, rv);
		check(rv, exp);
	endtask
	// one sample on every stream, outputs looked at after the taking edge
	task automatic pulse;
		av = 1'b1;
		dv = 1'b1;
		hv = 1'b1;
		step;
		av = 1'b0;
		dv = 1'b0;
		hv = 1'b0;
	endtask
	task automatic finish_test;
		$display("failures %0d checked %0d", failures, checked);
		if (failures == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_defaults;
		rd_chk(8'h05, 8'h00);
		rd_chk(8'h06, 8'h11);
		rd_chk(8'h07, 8'h01);
		rd_chk(8'h08, 8'h00);
		rd_chk(8'h09, 8'h40);
		check({fs, dem, bst, second_level_ctrl}, {3'h0, 2'h1, 2'h0, 1'b1});
		check(mute, 8'h80);
		check({mg, ms}, 2'b10);
		check({mad, aad}, 2'b00);
		check(rtick, 1'b0);
	endtask
	task automatic t_reserved;
		host_u.write_reg(8'h05, 8'hFF);
		host_u.write_reg(8'h07, 8'hFF);
		host_u.write_reg(8'h08, 8'hFF);
		host_u.write_reg(8'h09, 8'hFF);
		host_u.write_reg(8'h0F, 8'hFF);
		rd_chk(8'h05, 8'hE7);
		rd_chk(8'h07, 8'h3F);
		rd_chk(8'h08, 8'h7F);
		rd_chk(8'h09, 8'h7F);
		rd_chk(8'h0F, 8'h00);
		// low power down pin clears the bank
		pdn_n = 1'b0;
		step;
		pdn_n = 1'b1;
		rd_chk(8'h05, 8'h00);
	endtask
	task automatic t_speaker;
		check({oe, neg}, 2'b00);
		spk_pwr = 1'b1;
		step;
		check({oe, neg}, 2'b01);
		host_u.write_reg(8'h05, 8'h01);
		check({oe, neg}, 2'b10);
	endtask
	task automatic t_streams;
		host_u.write_reg(8'h05, 8'h06);
		adc = 16'h1234;
		din = 16'h5678;
		hl = 16'hFFFE;
		hr = 16'h0004;
		pulse;
		check(dout, 16'h1234);
		check(dov, 1'b1);
		step;
		check(dov, 1'b0);
		check(hlo, 16'h0001);
		check(hro, 16'h0001);
		hl = 16'h8000;
		hr = 16'h8000;
		pulse;
		check(hro, 16'h8000);
		host_u.write_reg(8'h05, 8'h00);
		hl = 16'h1000;
		hr = 16'h3000;
		pulse;
		check(dout, 16'h5678);
		check(hlo, 16'h1000);
		check(hro, 16'h3000);
	endtask
	task automatic t_atten;
		host_u.write_reg(8'h0D, 8'h07);
		host_u.write_reg(8'h0C, 8'h30);
		check({att_l, att_r}, 16'h3030);
		host_u.write_reg(8'h06, 8'hCE);
		check({att_r, 2'b00, dem, 2'b00, bst}, {8'h07, 8'h23});
	endtask
	task automatic t_mic;
		host_u.write_reg(8'h07, 8'h3E);
		check({isup, esup}, 2'b00);
		check({mg, ms}, 2'b01);
		check(mad, 1'b1);
		check(aad, 1'b1);
		mic_pwr = 1'b1;
		step;
		check({isup, esup}, 2'b11);
	endtask
	// host gain waits for a sign change; limiter acts at once, then spaced by 4/fs
	task automatic t_gain;
		int n;
		host_u.write_reg(8'h0B, 8'h20);
		check(gain, 7'h10);
		adc = 16'h8000;
		pulse;
		check(gain, 7'h20);
		host_u.write_reg(8'h08, 8'h03);
		host_u.write_reg(8'h09, 8'h3C);
		adc = 16'h7000;
		pulse;
		check(gain, 7'h1C);
		step;
		av = 1'b1;
		step;
		check(gain, 7'h1C);
		for (n = 0; n < 20000 && gain === 7'h1C; n++)
			step;
		av = 1'b0;
		check(n > 14000, 1'b1);
		check(gain, 7'h18);
	endtask
	// fastest ramp: one step per sample period, so a step lands well in bound
	task automatic t_mute;
		int n;
		host_u.write_reg(8'h05, 8'h20);
		check(fs, 3'h1);
		host_u.write_reg(8'h06, 8'hE0);
		for (n = 0; n < 20000 && mute === 8'h80; n++)
			step;
		check(mute, 8'h7F);
	endtask
	initial
	begin
		repeat (20) @(posedge mclk);
		#1;
		srst = 1'b0;
		t_defaults();
		t_reserved();
		t_speaker();
		t_streams();
		t_atten();
		t_mic();
		t_mute();
		t_gain();
		finish_test();
	end
endmodule
`default_nettype wire

// >>> verilog/cmdc_fs_timer.sv
// sample-period timer counting half-fs ticks up to a limit
// assumes tick is a one-cycle pulse at twice the sample rate
`default_nettype none
module cmdc_fs_timer #(
	parameter int W = 13
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic run,
	input wire logic restart,
	input wire logic tick,
	input wire logic [W-1:0] limit,
	// expiry pulse
	output logic done
);
	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;
	logic hit;

	// ****************************************
	// counter
	// ****************************************
	// restart wins over tick so a fresh period is always whole
	assign count_next = W'(count_reg + 1'b1);
	assign hit = tick && (count_next >= limit);
	always_ff @(posedge clk)
	begin
		if (rst || !run || restart)
			count_reg <= '0;
		else if (hit)
			count_reg <= '0;
		else if (tick)
			count_reg <= count_next;
	end

	// expiry pulse, registered
	always_ff @(posedge clk)
	begin
		if (rst)
			done <= 1'b0;
		else
			done <= run && !restart && hit;
	end
endmodule
`default_nettype wire

// >>> verilog/cmdc_pkg.sv
// constants shared by the codec mode, dac and level control register slice
// assumes a 200 MHz core clock and 8-bit register writes from the serial port decoder
`default_nettype none
package cmdc_pkg;
	// ****************************************
	// clock and timing
	// ****************************************
	localparam int CLK_HZ = 200_000_000;
	localparam int DIV_W = 16;
	localparam int TMR_W = 13;
	localparam int DATA_W = 16;
	localparam int GAIN_W = 7;
	// rates per sample_rate_sel code, code 0 is 44.1 kHz
	localparam int FS_RATE_HZ [8] = '{44100, 48000, 32000, 24000, 22050, 16000, 11025, 8000};
	// mclk cycles per half sample period, rounded down
	function automatic logic [DIV_W-1:0] half_fs_cycles(input logic [2:0] code);
		half_fs_cycles = DIV_W'(CLK_HZ / (2 * FS_RATE_HZ[code]));
	endfunction
	// all timer limits are in half sample periods
	localparam logic [TMR_W-1:0] MUTE_BASE_HALF = 13'h0010;
	localparam logic [TMR_W-1:0] LIM_BASE_HALF = 13'h0001;
	localparam logic [TMR_W-1:0] WAIT_BASE_HALF = 13'h0100;
	localparam logic [TMR_W-1:0] SECOND_LEVEL_CTRL_SLOW_HALF = 13'h1000;
	localparam logic [TMR_W-1:0] SECOND_LEVEL_CTRL_FAST_HALF = 13'h0400;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] ADDR_MODE = 8'h05;
	localparam logic [7:0] ADDR_DAC = 8'h06;
	localparam logic [7:0] ADDR_MIC = 8'h07;
	localparam logic [7:0] ADDR_TIMER = 8'h08;
	localparam logic [7:0] ADDR_ALC = 8'h09;
	localparam logic [7:0] ADDR_GAIN = 8'h0B;
	localparam logic [7:0] ADDR_ATT_L = 8'h0C;
	localparam logic [7:0] ADDR_ATT_R = 8'h0D;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_DAC = 8'h11;
	localparam logic [7:0] RST_MIC = 8'h01;
	localparam logic [7:0] RST_TIMER = 8'h00;
	localparam logic [7:0] RST_ALC = 8'h40;
	localparam logic [7:0] RST_ATT = 8'h00;
	localparam logic [GAIN_W-1:0] RST_GAIN = 7'h10;
	localparam logic [GAIN_W-1:0] GAIN_REF = 7'h36;
	// writable bits, reserved ones read zero
	localparam logic [7:0] MASK_MODE = 8'hE7;
	localparam logic [7:0] MASK_MIC = 8'h3F;
	localparam logic [7:0] MASK_TIMER = 8'h7F;
	localparam logic [7:0] MASK_ALC = 8'h7F;
	// field positions
	localparam int MODE_SPK_SAVE = 0;
	localparam int MODE_LOOP = 1;
	localparam int MODE_HP_MONO = 2;
	localparam int MODE_FS_LSB = 5;
	localparam int DAC_DEEMPH_LSB = 0;
	localparam int DAC_BOOST_LSB = 2;
	localparam int DAC_ATT_LINK = 4;
	localparam int DAC_SILENCE = 5;
	localparam int DAC_RAMP_LSB = 6;
	localparam int MIC_GAIN1 = 0;
	localparam int MIC_SRC = 1;
	localparam int MIC_TO_ADC = 2;
	localparam int MIC_SUP_INT = 3;
	localparam int MIC_SUP_EXT = 4;
	localparam int MIC_AUX_ADC = 5;
	localparam int TMR_LIM_LSB = 0;
	localparam int TMR_WAIT_LSB = 2;
	localparam int TMR_ZC_LSB = 4;
	localparam int TMR_SECOND_LEVEL_CTRL_REC = 6;
	localparam int ALC_THRESH = 0;
	localparam int ALC_REC_STEP = 1;
	localparam int ALC_LIM_LSB = 2;
	localparam int ALC_ZC_OFF = 4;
	localparam int ALC_EN1 = 5;
	localparam int ALC_EN2 = 6;
	// ****************************************
	// signal levels and mute
	// ****************************************
	localparam logic [DATA_W-1:0] LVL_M4DB = 16'h50C3;
	localparam logic [DATA_W-1:0] LVL_M6DB = 16'h4026;
	localparam logic [DATA_W-1:0] LVL_M8DB = 16'h32F5;
	localparam logic [7:0] MUTE_FULL = 8'h80;
	// gain apply sequencer
	typedef enum logic [1:0] {CMDC_IDLE = 2'b01, CMDC_WAIT_ZC = 2'b10} cmdc_state_t;
endpackage
`default_nettype wire

// >>> verilog/cmdc_regs.sv
// mode, dac, mic routing and level control registers with their datapath effects
// assumes register strobes come from the serial control port decoder, one access a cycle
// Behaviour
// - speaker save 0 floats positive output, holds negative at half supply
// - speaker save acts only with speaker power; power bit resets low
// - loopback sends adc data to dac, ignoring external dac data
// - headphone mono drives (L+R)/2 to both channels
// - sample rate field resets to 000, meaning 44.1 kHz
// - de-emphasis field resets to 01, de-emphasis off
// - bass boost field resets to 00, boost off
// - linked attenuators: left write sets both, stored right unchanged
// - soft mute ramps dac output down digitally, apart from attenuator
// - mute ramp lasts 1024, 512, 256 or 128 sample periods
// - mic source resets internal; first mic gain resets to +20 dB
// - mic to adc switch feeds level control output into adc
// - aux to adc switch feeds aux input into adc
// - mic supply switches act only with mic block power
// - limiter without zero cross applies at once, spaced 0.5 to 4/fs
// - recovery waits 128 to 1024/fs without limiting before stepping
// - host, recovery, zero-cross limiter changes wait zero cross or timeout
// - second level control recovery period 2048/fs or 512/fs
// - limiter thresholds -6/-4 dBFS, reset bands two dB below
// - first level control resets off, second resets on
// - zero-cross field 0 waits for crossing, 1 applies limiter steps immediately
// - limiter lowers gain 1 to 4 steps, clipping at zero
// - recovery raises gain 1 or 2 steps, never past reference
`default_nettype none
module cmdc_regs (
	// clock and reset
	input wire logic MCLK,
	input wire logic SRST,
	input wire logic POWER_DOWN_PIN_N,
	// register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	// power bits held elsewhere
	input wire logic SPEAKER_BLOCK_POWER,
	input wire logic MIC_BLOCK_POWER,
	// adc and dac sample streams
	input wire logic [cmdc_pkg::DATA_W-1:0] ADC_DATA,
	input wire logic ADC_VALID,
	input wire logic [cmdc_pkg::DATA_W-1:0] DAC_IN_DATA,
	input wire logic DAC_IN_VALID,
	output logic [cmdc_pkg::DATA_W-1:0] DAC_OUT_DATA,
	output logic DAC_OUT_VALID,
	// headphone mix
	input wire logic [cmdc_pkg::DATA_W-1:0] HP_LEFT_IN,
	input wire logic [cmdc_pkg::DATA_W-1:0] HP_RIGHT_IN,
	input wire logic HP_IN_VALID,
	output logic [cmdc_pkg::DATA_W-1:0] HP_LEFT_OUT,
	output logic [cmdc_pkg::DATA_W-1:0] HP_RIGHT_OUT,
	// speaker pins
	output logic SPEAKER_POS_OUT_OE,
	output logic SPEAKER_NEG_OUT_HALF,
	// dac controls
	output logic [2:0] SAMPLE_RATE_SEL,
	output logic [1:0] DEEMPH_SEL,
	output logic [1:0] BASS_BOOST_SEL,
	output logic [7:0] LEFT_ATTEN,
	output logic [7:0] RIGHT_ATTEN,
	output logic [7:0] MUTE_GAIN,
	// mic and adc routing
	output logic FIRST_MIC_GAIN,
	output logic MIC_SOURCE_SEL,
	output logic MIC_TO_ADC_SWITCH,
	output logic AUX_TO_ADC_SWITCH,
	output logic INTERNAL_MIC_SUPPLY,
	output logic EXTERNAL_MIC_SUPPLY,
	// level control
	output logic [cmdc_pkg::GAIN_W-1:0] INPUT_GAIN_STAGE,
	output logic SECOND_LEVEL_CTRL,
	output logic SECOND_RECOVERY_TICK
);
	import cmdc_pkg::*;

	logic reg_rst;
	logic [7:0] mode_reg, dac_reg, mic_reg, timer_reg, alc_reg;
	logic [7:0] left_atten_reg, right_atten_reg;
	logic [GAIN_W-1:0] gain_wr_reg, gain_reg, target_reg;
	logic [7:0] rdata_next;
	logic wr_mode, wr_dac, wr_mic, wr_timer, wr_alc, wr_gain, wr_att_l, wr_att_r;

	// ****************************************
	// register file
	// ****************************************
	// power-down pin clears the bank just like the core reset
	assign reg_rst = SRST || !POWER_DOWN_PIN_N;
	assign wr_mode = REG_WR && (REG_ADDR == ADDR_MODE);
	assign wr_dac = REG_WR && (REG_ADDR == ADDR_DAC);
	assign wr_mic = REG_WR && (REG_ADDR == ADDR_MIC);
	assign wr_timer = REG_WR && (REG_ADDR == ADDR_TIMER);
	assign wr_alc = REG_WR && (REG_ADDR == ADDR_ALC);
	assign wr_gain = REG_WR && (REG_ADDR == ADDR_GAIN);
	assign wr_att_l = REG_WR && (REG_ADDR == ADDR_ATT_L);
	assign wr_att_r = REG_WR && (REG_ADDR == ADDR_ATT_R);

	// control registers, reserved bits masked at write
	// reset values of every field
	always_ff @(posedge MCLK)
	begin
		if (reg_rst)
		begin
			mode_reg <= RST_MODE;
			dac_reg <= RST_DAC;
			mic_reg <= RST_MIC;
			timer_reg <= RST_TIMER;
			alc_reg <= RST_ALC;
			gain_wr_reg <= RST_GAIN;
		end
		else
		begin
			if (wr_mode)
				mode_reg <= REG_WDATA & MASK_MODE;
			if (wr_dac)
				dac_reg <= REG_WDATA;
			if (wr_mic)
				mic_reg <= REG_WDATA & MASK_MIC;
			if (wr_timer)
				timer_reg <= REG_WDATA & MASK_TIMER;
			if (wr_alc)
				alc_reg <= REG_WDATA & MASK_ALC;
			if (wr_gain)
				gain_wr_reg <= REG_WDATA[GAIN_W-1:0];
		end
	end

	// attenuator pair
	always_ff @(posedge MCLK)
	begin
		if (reg_rst)
		begin
			left_atten_reg <= RST_ATT;
			right_atten_reg <= RST_ATT;
		end
		else
		begin
			if (wr_att_l)
				left_atten_reg <= REG_WDATA;
			if (wr_att_r)
				right_atten_reg <= REG_WDATA;
		end
	end

	// read mux, unmapped addresses answer zero
	always_comb
	begin
		case (REG_ADDR)
			ADDR_MODE: rdata_next = mode_reg;
			ADDR_DAC: rdata_next = dac_reg;
			ADDR_MIC: rdata_next = mic_reg;
			ADDR_TIMER: rdata_next = timer_reg;
			ADDR_ALC: rdata_next = alc_reg;
			ADDR_GAIN: rdata_next = {1'b0, gain_wr_reg};
			ADDR_ATT_L: rdata_next = left_atten_reg;
			ADDR_ATT_R: rdata_next = right_atten_reg;
			default: rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge MCLK)
	begin
		if (SRST)
			REG_RDATA <= 8'h00;
		else if (REG_RD)
			REG_RDATA <= rdata_next;
	end

	// ****************************************
	// static controls
	// ****************************************
	assign SAMPLE_RATE_SEL = mode_reg[MODE_FS_LSB +: 3];
	assign DEEMPH_SEL = dac_reg[DAC_DEEMPH_LSB +: 2];
	assign BASS_BOOST_SEL = dac_reg[DAC_BOOST_LSB +: 2];
	assign LEFT_ATTEN = left_atten_reg;
	assign RIGHT_ATTEN = dac_reg[DAC_ATT_LINK] ? left_atten_reg : right_atten_reg;
	assign FIRST_MIC_GAIN = mic_reg[MIC_GAIN1];
	assign MIC_SOURCE_SEL = mic_reg[MIC_SRC];
	assign MIC_TO_ADC_SWITCH = mic_reg[MIC_TO_ADC];
	assign AUX_TO_ADC_SWITCH = mic_reg[MIC_AUX_ADC];
	// supplies gated by mic block power
	assign INTERNAL_MIC_SUPPLY = mic_reg[MIC_SUP_INT] && MIC_BLOCK_POWER;
	assign EXTERNAL_MIC_SUPPLY = mic_reg[MIC_SUP_EXT] && MIC_BLOCK_POWER;
	// save bit clear floats positive pin, parks negative pin
	assign SPEAKER_POS_OUT_OE = SPEAKER_BLOCK_POWER && mode_reg[MODE_SPK_SAVE];
	// without speaker power both pins stay released
	assign SPEAKER_NEG_OUT_HALF = SPEAKER_BLOCK_POWER && !mode_reg[MODE_SPK_SAVE];
	assign SECOND_LEVEL_CTRL = alc_reg[ALC_EN2];
	assign INPUT_GAIN_STAGE = gain_reg;

	// ****************************************
	// sample streams
	// ****************************************
	// loopback takes adc samples, external data dropped
	always_ff @(posedge MCLK)
	begin
		if (SRST)
		begin
			DAC_OUT_DATA <= '0;
			DAC_OUT_VALID <= 1'b0;
		end
		else if (mode_reg[MODE_LOOP])
		begin
			DAC_OUT_DATA <= ADC_VALID ? ADC_DATA : DAC_OUT_DATA;
			DAC_OUT_VALID <= ADC_VALID;
		end
		else
		begin
			DAC_OUT_DATA <= DAC_IN_VALID ? DAC_IN_DATA : DAC_OUT_DATA;
			DAC_OUT_VALID <= DAC_IN_VALID;
		end
	end

	// mono mix, sum kept one bit wider to avoid overflow
	logic signed [DATA_W:0] hp_sum;
	assign hp_sum = $signed({HP_LEFT_IN[DATA_W-1], HP_LEFT_IN}) + $signed({HP_RIGHT_IN[DATA_W-1], HP_RIGHT_IN});
	always_ff @(posedge MCLK)
	begin
		if (SRST)
		begin
			HP_LEFT_OUT <= '0;
			HP_RIGHT_OUT <= '0;
		end
		else if (HP_IN_VALID)
		begin
			HP_LEFT_OUT <= mode_reg[MODE_HP_MONO] ? hp_sum[DATA_W:1] : HP_LEFT_IN;
			HP_RIGHT_OUT <= mode_reg[MODE_HP_MONO] ? hp_sum[DATA_W:1] : HP_RIGHT_IN;
		end
	end

	// ****************************************
	// sample tick and timers
	// ****************************************
	logic [DIV_W-1:0] div_reg;
	logic half_tick;
	// tick rate follows the selected sample rate
	assign half_tick = (div_reg == '0);
	always_ff @(posedge MCLK)
	begin
		if (SRST || half_tick)
			div_reg <= DIV_W'(half_fs_cycles(SAMPLE_RATE_SEL) - 1'b1);
		else
			div_reg <= DIV_W'(div_reg - 1'b1);
	end

	cmdc_pkg::cmdc_state_t state_reg;
	logic first_level_ctrl_en, limit_hit, band_hit, zc_seen, imm_apply, zc_apply, lim_hold_reg;
	logic mute_step, lim_done, wait_done, zc_done;
	logic [DATA_W-1:0] mag;
	logic [DATA_W-1:0] lim_lvl, band_lvl;
	logic adc_sign_reg;

	// ramp step of 1/128 of the selected mute time
	cmdc_fs_timer #(.W(TMR_W)) u_mute_tmr (.clk(MCLK), .rst(SRST), .run(1'b1), .restart(1'b0),
		.tick(half_tick), .limit(MUTE_BASE_HALF >> dac_reg[DAC_RAMP_LSB +: 2]), .done(mute_step));
	// limiter spacing while a change is held
	cmdc_fs_timer #(.W(TMR_W)) u_lim_tmr (.clk(MCLK), .rst(SRST), .run(lim_hold_reg), .restart(imm_apply),
		.tick(half_tick), .limit(LIM_BASE_HALF << timer_reg[TMR_LIM_LSB +: 2]), .done(lim_done));
	// recovery wait restarted by any limiting or reset-band level
	cmdc_fs_timer #(.W(TMR_W)) u_wait_tmr (.clk(MCLK), .rst(SRST), .run(first_level_ctrl_en), .restart(limit_hit || band_hit),
		.tick(half_tick), .limit(WAIT_BASE_HALF << timer_reg[TMR_WAIT_LSB +: 2]), .done(wait_done));
	// zero-cross timeout, started on entering the wait
	cmdc_fs_timer #(.W(TMR_W)) u_zc_tmr (.clk(MCLK), .rst(SRST), .run(state_reg == CMDC_WAIT_ZC),
		.restart(1'b0), .tick(half_tick), .limit(WAIT_BASE_HALF << timer_reg[TMR_ZC_LSB +: 2]), .done(zc_done));
	cmdc_fs_timer #(.W(TMR_W)) u_second_level_ctrl_tmr (.clk(MCLK), .rst(SRST), .run(SECOND_LEVEL_CTRL), .restart(1'b0),
		.tick(half_tick), .limit(timer_reg[TMR_SECOND_LEVEL_CTRL_REC] ? SECOND_LEVEL_CTRL_FAST_HALF : SECOND_LEVEL_CTRL_SLOW_HALF),
		.done(SECOND_RECOVERY_TICK));

	// ****************************************
	// soft mute
	// ****************************************
	// digital ramp, independent of attenuator values
	always_ff @(posedge MCLK)
	begin
		if (reg_rst)
			MUTE_GAIN <= MUTE_FULL;
		else if (mute_step && dac_reg[DAC_SILENCE] && MUTE_GAIN != 8'h00)
			MUTE_GAIN <= MUTE_GAIN - 8'h01;
		else if (mute_step && !dac_reg[DAC_SILENCE] && MUTE_GAIN != MUTE_FULL)
			MUTE_GAIN <= MUTE_GAIN + 8'h01;
	end

	// ****************************************
	// level control
	// ****************************************
	assign first_level_ctrl_en = alc_reg[ALC_EN1];
	assign mag = ADC_DATA[DATA_W-1] ? DATA_W'(~ADC_DATA + 1'b1) : ADC_DATA;
	assign lim_lvl = alc_reg[ALC_THRESH] ? LVL_M4DB : LVL_M6DB;
	assign band_lvl = alc_reg[ALC_THRESH] ? LVL_M6DB : LVL_M8DB;
	assign limit_hit = first_level_ctrl_en && ADC_VALID && (mag >= lim_lvl);
	assign band_hit = first_level_ctrl_en && ADC_VALID && (mag < lim_lvl) && (mag >= band_lvl);
	assign zc_seen = ADC_VALID && (ADC_DATA[DATA_W-1] != adc_sign_reg);

	always_ff @(posedge MCLK)
	begin
		if (SRST)
			adc_sign_reg <= 1'b0;
		else if (ADC_VALID)
			adc_sign_reg <= ADC_DATA[DATA_W-1];
	end

	// candidate gains
	logic [GAIN_W-1:0] lim_step, rec_step, lim_gain, rec_gain;
	// one to four steps down, clipped at zero
	assign lim_step = GAIN_W'(alc_reg[ALC_LIM_LSB +: 2]) + 7'h01;
	assign lim_gain = (gain_reg > lim_step) ? GAIN_W'(gain_reg - lim_step) : '0;
	// one or two steps up, capped at the reference
	assign rec_step = alc_reg[ALC_REC_STEP] ? 7'h02 : 7'h01;
	assign rec_gain = (GAIN_W'(gain_reg + rec_step) > GAIN_REF) ? GAIN_REF : GAIN_W'(gain_reg + rec_step);

	// zero-cross off means limiter acts at once, unless spacing holds it
	assign imm_apply = limit_hit && alc_reg[ALC_ZC_OFF] && !lim_hold_reg;
	assign zc_apply = (state_reg == CMDC_WAIT_ZC) && (zc_seen || zc_done);

	// hold the limiter until the period has elapsed
	always_ff @(posedge MCLK)
	begin
		if (reg_rst)
			lim_hold_reg <= 1'b0;
		else if (imm_apply)
			lim_hold_reg <= 1'b1;
		else if (lim_done)
			lim_hold_reg <= 1'b0;
	end

	// deferred changes wait for a crossing or the timeout
	always_ff @(posedge MCLK)
	begin
		if (reg_rst)
		begin
			state_reg <= CMDC_IDLE;
			gain_reg <= RST_GAIN;
			target_reg <= RST_GAIN;
		end
		else if (imm_apply)
		begin
			gain_reg <= lim_gain;
			state_reg <= CMDC_IDLE;
		end
		else
		begin
			case (state_reg)
				CMDC_IDLE:
				begin
					if (limit_hit && !alc_reg[ALC_ZC_OFF])
					begin
						target_reg <= lim_gain;
						state_reg <= CMDC_WAIT_ZC;
					end
					else if (wr_gain && !first_level_ctrl_en)
					begin
						target_reg <= REG_WDATA[GAIN_W-1:0];
						state_reg <= CMDC_WAIT_ZC;
					end
					else if (wait_done && gain_reg < GAIN_REF)
					begin
						target_reg <= rec_gain;
						state_reg <= CMDC_WAIT_ZC;
					end
				end
				CMDC_WAIT_ZC:
				begin
					if (zc_apply)
					begin
						gain_reg <= target_reg;
						state_reg <= CMDC_IDLE;
					end
				end
				default: state_reg <= CMDC_IDLE;
			endcase
		end
	end

	// ****************************************
	// checks
	// ****************************************
	a_reserved_zero: assert property (@(posedge MCLK) disable iff (SRST)
		(REG_RD && REG_ADDR == ADDR_MODE) |=> (REG_RDATA[4:3] == 2'b00))
		else $error("reserved mode bits read nonzero");
	a_link_right_hold: assert property (@(posedge MCLK) disable iff (reg_rst)
		(wr_att_l && dac_reg[DAC_ATT_LINK] && !wr_att_r && !wr_dac) |=>
		($stable(right_atten_reg) && RIGHT_ATTEN == $past(REG_WDATA)))
		else $error("linked left write disturbed right value");
	a_loop_source: assert property (@(posedge MCLK) disable iff (SRST)
		(mode_reg[MODE_LOOP] && ADC_VALID && !wr_mode) |=> (DAC_OUT_VALID && DAC_OUT_DATA == $past(ADC_DATA)))
		else $error("loopback did not pass adc data");
	a_mono_equal: assert property (@(posedge MCLK) disable iff (SRST)
		(mode_reg[MODE_HP_MONO] && HP_IN_VALID && !wr_mode) |=> (HP_LEFT_OUT == HP_RIGHT_OUT))
		else $error("mono headphone channels differ");
	a_mute_falls: assert property (@(posedge MCLK) disable iff (reg_rst)
		(dac_reg[DAC_SILENCE] && !wr_dac) |=> (MUTE_GAIN <= $past(MUTE_GAIN)))
		else $error("mute gain rose while muted");
	a_gain_ceiling: assert property (@(posedge MCLK) disable iff (reg_rst)
		(state_reg == CMDC_IDLE && wait_done && !limit_hit && !wr_gain) ##1 (zc_apply && !imm_apply)
		|=> (gain_reg <= GAIN_REF))
		else $error("recovery exceeded reference gain");
	a_reset_defaults: assert property (@(posedge MCLK)
		reg_rst |=> (alc_reg == RST_ALC && dac_reg == RST_DAC && mic_reg == RST_MIC && gain_reg == RST_GAIN))
		else $error("register defaults wrong after reset");
	a_mic_supply_gate: assert property (@(posedge MCLK) disable iff (SRST)
		!MIC_BLOCK_POWER |-> !(INTERNAL_MIC_SUPPLY || EXTERNAL_MIC_SUPPLY))
		else $error("mic supply on without block power");
	a_limit_spacing: assert property (@(posedge MCLK) disable iff (reg_rst)
		imm_apply |=> !imm_apply [*2])
		else $error("limiter changes too close together");
endmodule
`default_nettype wire
